// ==== tccp_timer.sv ====
// How it works
// R1 - free-running counts 0x0000 up to 0xFFFF, then wraps to 0x0000
// R2 - free-running terminal count sets shared flag and overflow flag
// R3 - overflow request only when overflow mask and irq enable both set
// R4 - reading count low latches high byte; software reads low first
// R5 - any write to count low clears the whole counter
// R6 - nonzero counter mode runs the counter, 00 holds its value
// R7 - modulo counts up and wraps to zero at channel 0 compare value
// R8 - modulo terminal value sets shared flag and overflow flag
// R9 - up/down counts zero to channel 0 value and back repeatedly
// R10 - up/down sets shared and overflow flags on reaching zero
// R11 - capture channel pin is input, compare channel pin is output
// R12 - selected pin edge copies counter into capture register while running
// R13 - capture inputs synchronised; source holds pulses over one clock
// R14 - capture sets shared and channel flags; request needs mask and enable
// R15 - compare match sets, clears or toggles the output, glitch free
// R16 - compare low byte is buffered until the high byte is written
// R17 - modes 1-3 load at high write, others load at zero count
// R18 - channel 0 offers no compare modes 5 to 7
// R19 - match sets channel flag; up/down sets channel 0 flag at zero
// R20 - pending flag needs clearing; setting mask with flag set requests
// R21 - one dma trigger pulse per channel on its compare event
// R22 - up/down output period is twice the channel 0 value
// R23 - prescale codes 00..11 divide the tick by 1, 8, 32, 128
// R24 - mode codes: 00 stop, 01 free, 10 modulo, 11 up/down
// R25 - mode 011 sets on up match, clears at zero/down match; 100 inverse
// R26 - writing 1 to a flag has no effect; writing 0 clears
// R27 - tick is a one-cycle enable; prescaler advances only on it
// R28 - up/down turns on the same edge the top value is reached
//
// Added by the designer: the AHB-Lite interface to the registers and the placing of the registers.
`include "tccp_regs.svh"
module tccp_timer (
   // clock and reset
   input  wire logic                   hclk,
   input  wire logic                   hresetn,
   // register bus
   input  wire tccp_pkg::tccp_ahb_req_t ahb_req,
   input  wire logic [31:0]            hwdata,
   output tccp_pkg::tccp_ahb_rsp_t     ahb_rsp,
   // timer tick
   input  wire logic                   tick_en,
   // channel pins
   input  wire logic [2:0]             pin_in,
   output logic [2:0]                  pin_out,
   output logic [2:0]                  pin_oe,
   // events
   output logic                        irq_req,
   output logic [2:0]                  dma_trig
);
   import tccp_pkg::*;

   tccp_state_t q;
   tccp_state_t d;
   logic        run;
   logic        act;
   logic        ovf;
   logic [2:0]  chset;
   logic [6:0]  pmask;
   logic        wr_cntl;
   logic [2:0]  capev;
   logic [2:0]  cmpev;

   // ************************************************
   // counter, channels and register access
   // ************************************************
   always_comb begin
      logic [7:0]  w;
      logic [1:0]  ch;
      logic        up;
      logic        zero;
      logic        match;
      logic [2:0]  cm;
      logic [15:0] nv;
      w     = hwdata[7:0];
      ch    = 2'h0;
      up    = 1'b0;
      zero  = 1'b0;
      match = 1'b0;
      cm    = 3'h0;
      nv    = 16'h0000;
      d     = q;
      ovf   = 1'b0;
      chset = 3'h0;
      capev = 3'h0;
      cmpev = 3'h0;
      d.dma = 3'h0;
      unique case (q.ctl[3:2])                                 // R23
         2'h0: pmask = `TCCP_PSC_DIV1;
         2'h1: pmask = `TCCP_PSC_DIV8;
         2'h2: pmask = `TCCP_PSC_DIV32;
         2'h3: pmask = `TCCP_PSC_DIV128;
      endcase
      run = q.ctl[1:0] != `TCCP_MODE_STOP;                    // R6
      if (tick_en)
         d.psc = q.psc + 7'h01;                               // R27
      act = run && tick_en && ((q.psc & pmask) == pmask);     // R27
      if (act) begin
         unique case (q.ctl[1:0])                             // R24
            `TCCP_MODE_FREE: begin
               d.cnt = q.cnt + `TCCP_CNT_ONE;                 // R1
               ovf   = q.cnt == `TCCP_CNT_TOP;                // R2
            end
            `TCCP_MODE_MOD: begin
               if (q.cnt == q.cv[0]) begin                    // R7
                  d.cnt = `TCCP_CNT_ZERO;
                  ovf   = 1'b1;                               // R8
               end else begin
                  d.cnt = q.cnt + `TCCP_CNT_ONE;
               end
            end
            `TCCP_MODE_UPDN: begin
               if (!q.down && !(q.cnt >= q.cv[0] && q.cnt != `TCCP_CNT_ZERO)) begin
                  d.cnt = q.cnt + `TCCP_CNT_ONE;              // R9
               end else begin
                  // turn at the top on this same edge, no dwell
                  d.down = 1'b1;                              // R28
                  d.cnt  = q.cnt - `TCCP_CNT_ONE;             // R22
                  if (q.cnt == `TCCP_CNT_ONE) begin
                     d.down = 1'b0;
                     ovf    = 1'b1;                           // R10
                  end
               end
            end
            default: begin
            end
         endcase
      end
      for (int n = 0; n < 3; n++) begin
         d.s1[n] = pin_in[n];                                 // R13
         d.s2[n] = q.s1[n];
         d.s3[n] = q.s2[n];
         cm      = q.cctl[n][5:3];
         if (q.pend[n] && q.cnt == `TCCP_CNT_ZERO) begin
            d.cv[n]   = q.cvw[n];                             // R17
            d.pend[n] = 1'b0;
         end
         if (q.cctl[n][`TCCP_CCTL_CMPM]) begin
            match = act && q.cnt == q.cv[n];
            up    = q.ctl[1:0] != `TCCP_MODE_UPDN || !q.down;
            zero  = act && q.cnt == `TCCP_CNT_ZERO && q.ctl[1:0] != `TCCP_MODE_UPDN;
            cmpev[n] = match;
            if (!(n == 0 && cm > `TCCP_CMP_UPCLR)) begin      // R18
               unique case (cm)                               // R15
                  `TCCP_CMP_SET: if (match) d.pin[n] = 1'b1;
                  `TCCP_CMP_CLR: if (match) d.pin[n] = 1'b0;
                  `TCCP_CMP_TOG: if (match) d.pin[n] = !q.pin[n];
                  `TCCP_CMP_UPSET: begin                      // R25
                     if (match && up)
                        d.pin[n] = 1'b1;
                     else if ((match && !up) || zero)
                        d.pin[n] = 1'b0;
                  end
                  `TCCP_CMP_UPCLR: begin                      // R25
                     if (match && up)
                        d.pin[n] = 1'b0;
                     else if ((match && !up) || zero)
                        d.pin[n] = 1'b1;
                  end
                  default: begin
                  end
               endcase
            end
            chset[n] = match;                                 // R19
            d.dma[n] = match;                                 // R21
         end else if (run) begin
            unique case (q.cctl[n][1:0])                      // R12
               `TCCP_CAP_RISE: capev[n] = q.s2[n] && !q.s3[n];
               `TCCP_CAP_FALL: capev[n] = !q.s2[n] && q.s3[n];
               `TCCP_CAP_ANY:  capev[n] = q.s2[n] != q.s3[n];
               default:        capev[n] = 1'b0;
            endcase
            if (capev[n]) begin
               d.cv[n]   = q.cnt;                             // R12
               d.cvw[n]  = q.cnt;
               d.pend[n] = 1'b0;
               chset[n]  = 1'b1;                              // R14
            end
         end
      end
      if (q.ctl[1:0] == `TCCP_MODE_UPDN && q.cctl[0][`TCCP_CCTL_CMPM])
         chset[0] = ovf;                                      // R19
      // bus: address phase, then one stall cycle that does the access
      d.dph = ahb_req.hsel && ahb_req.htrans[1] && ahb_req.hready;
      d.dwr = ahb_req.hwrite;
      d.didx = (ahb_req.haddr[31:10] == 22'h0 && ahb_req.haddr[1:0] == 2'h0)
               ? ahb_req.haddr[9:2] : 8'h00;
      wr_cntl = q.dph && q.dwr && q.didx == `TCCP_IDX_CNTL;
      d.ctl[7:4] = q.ctl[7:4];
      d.cfg[`TCCP_CFG_SHF] = q.cfg[`TCCP_CFG_SHF];
      if (q.dph && q.dwr) begin
         if (q.didx == `TCCP_IDX_CNTL) begin
            d.cnt  = `TCCP_CNT_ZERO;                          // R5
            d.down = 1'b0;
         end
         if (q.didx == `TCCP_IDX_CTL) begin
            d.ctl[7:4] = q.ctl[7:4] & w[7:4];                 // R26
            d.ctl[3:0] = w[3:0];                              // R6
         end
         if (q.didx == `TCCP_IDX_CFG) begin
            d.cfg[`TCCP_CFG_SHF] = q.cfg[`TCCP_CFG_SHF] & w[0]; // R26
            d.cfg[2:1] = w[2:1];
         end
         for (int n = 0; n < 3; n++) begin
            ch = 2'(n);
            if (q.didx == `TCCP_IDX_CCTL0 + {6'h0, ch})
               d.cctl[n] = {1'b0, w[6:0]};
            if (q.didx == `TCCP_IDX_CVL0 + {5'h0, ch, 1'b0})
               d.lob[n] = w;                                  // R16
            if (q.didx == `TCCP_IDX_CVL0 + {5'h0, ch, 1'b1} && !capev[n]) begin
               nv = {w, q.lob[n]};
               d.cvw[n] = nv;                                 // R16
               cm = q.cctl[n][5:3];
               if (cm >= `TCCP_CMP_CLR && cm <= `TCCP_CMP_UPSET) begin
                  d.cv[n]   = nv;                             // R17
                  d.pend[n] = 1'b0;
               end else begin
                  d.pend[n] = 1'b1;                           // R17
               end
            end
         end
      end
      // hardware set wins over a software clear in the same cycle
      d.ctl[`TCCP_CTL_OVF] = d.ctl[`TCCP_CTL_OVF] | ovf;      // R2
      d.ctl[7:5] = d.ctl[7:5] | chset;                        // R14
      d.cfg[`TCCP_CFG_SHF] = d.cfg[`TCCP_CFG_SHF] | ovf | (|chset); // R8
      d.rdata = 32'h0000_0000;
      if (q.dph && !q.dwr) begin
         if (q.didx == `TCCP_IDX_CNTL) begin
            d.rdata[7:0] = q.cnt[7:0];
            d.cnth       = q.cnt[15:8];                       // R4
         end
         if (q.didx == `TCCP_IDX_CNTH)
            d.rdata[7:0] = q.cnth;                            // R4
         if (q.didx == `TCCP_IDX_CTL)
            d.rdata[7:0] = q.ctl;
         if (q.didx == `TCCP_IDX_CFG)
            d.rdata[2:0] = q.cfg;
         for (int n = 0; n < 3; n++) begin
            ch = 2'(n);
            if (q.didx == `TCCP_IDX_CCTL0 + {6'h0, ch})
               d.rdata[7:0] = q.cctl[n];
            if (q.didx == `TCCP_IDX_CVL0 + {5'h0, ch, 1'b0})
               d.rdata[7:0] = q.cvw[n][7:0];
            if (q.didx == `TCCP_IDX_CVL0 + {5'h0, ch, 1'b1})
               d.rdata[7:0] = q.cvw[n][15:8];
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         q         <= '0;
         q.ctl     <= `TCCP_CTL_RST;
         q.cctl[0] <= `TCCP_CCTL_RST;
         q.cctl[1] <= `TCCP_CCTL_RST;
         q.cctl[2] <= `TCCP_CCTL_RST;
         q.cfg     <= `TCCP_CFG_RST;
      end else begin
         q <= d;
      end
   end

   // ************************************************
   // outputs
   // ************************************************
   // level request, so a mask raised over a pending flag asks at once
   assign irq_req = q.cfg[`TCCP_CFG_IEN] &&                   // R20
                    ((q.ctl[`TCCP_CTL_OVF] && q.cfg[`TCCP_CFG_OVFM]) || // R3
                     (q.ctl[5] && q.cctl[0][`TCCP_CCTL_IM]) ||          // R14
                     (q.ctl[6] && q.cctl[1][`TCCP_CCTL_IM]) ||
                     (q.ctl[7] && q.cctl[2][`TCCP_CCTL_IM]));
   assign dma_trig  = q.dma;
   assign pin_out   = q.pin;
   assign pin_oe    = {q.cctl[2][`TCCP_CCTL_CMPM], q.cctl[1][`TCCP_CCTL_CMPM],
                       q.cctl[0][`TCCP_CCTL_CMPM]};           // R11
   assign ahb_rsp.hreadyout = !q.dph;
   assign ahb_rsp.hresp     = 1'b0;
   assign ahb_rsp.hrdata    = q.rdata;

   // ************************************************
   // checks
   // ************************************************
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   chk_free_wrap: assert property (act && q.ctl[1:0] == `TCCP_MODE_FREE // R1
      && q.cnt == `TCCP_CNT_TOP && !wr_cntl |=> q.cnt == `TCCP_CNT_ZERO && q.ctl[4])
      else $error("free-running wrap wrong");
   chk_free_step: assert property (act && q.ctl[1:0] == `TCCP_MODE_FREE && !wr_cntl // R2
      |=> q.cnt == $past(q.cnt) + `TCCP_CNT_ONE
      && ($past(q.cnt) != `TCCP_CNT_TOP || q.cfg[0]))
      else $error("free-running step or flag wrong");
   chk_mod_wrap: assert property (act && q.ctl[1:0] == `TCCP_MODE_MOD // R7
      && q.cnt == q.cv[0] && !wr_cntl |=> q.cnt == `TCCP_CNT_ZERO && q.ctl[4] && q.cfg[0])
      else $error("modulo wrap wrong");
   chk_ud_turn: assert property (act && q.ctl[1:0] == `TCCP_MODE_UPDN && !q.down // R28
      && q.cnt == q.cv[0] && q.cnt > `TCCP_CNT_ONE && !wr_cntl
      |=> q.down && q.cnt == $past(q.cnt) - `TCCP_CNT_ONE)
      else $error("up/down turn wrong");
   chk_cnt_clear: assert property (wr_cntl |=> q.cnt == `TCCP_CNT_ZERO) // R5
      else $error("count low write did not clear");
   chk_stop_hold: assert property (q.ctl[1:0] == `TCCP_MODE_STOP && !wr_cntl // R6
      |=> $stable(q.cnt))
      else $error("stopped counter moved");
   chk_cap_copy: assert property (capev[2] |=> q.cvw[2] == $past(q.cnt) // R12
      && q.cv[2] == $past(q.cnt) && q.ctl[7])
      else $error("capture value or flag wrong");
   chk_ovf_irq: assert property (ovf ##1 (q.cfg[2] && q.cfg[1]) |-> irq_req) // R3
      else $error("overflow request missing");
   chk_dma_pulse: assert property (cmpev[1] |=> dma_trig[1] // R21
      ##1 (!dma_trig[1] || $past(cmpev[1])))
      else $error("dma trigger not a pulse");
   chk_lo_buffer: assert property (q.dph && q.dwr // R16
      && q.didx == `TCCP_IDX_CVL0 && !capev[0] && !(q.pend[0] && q.cnt == `TCCP_CNT_ZERO)
      |=> $stable(q.cv[0]))
      else $error("low byte write reached compare");
   chk_ud_bottom: assert property (act && q.ctl[1:0] == `TCCP_MODE_UPDN && q.down // R10
      && q.cnt == `TCCP_CNT_ONE && !wr_cntl
      |=> q.cnt == `TCCP_CNT_ZERO && !q.down && q.ctl[4] && q.cfg[0])
      else $error("up/down bottom wrong");
   chk_cnth_latch: assert property (q.dph && !q.dwr && q.didx == `TCCP_IDX_CNTL // R4
      |=> q.cnth == $past(q.cnt[15:8]))
      else $error("count high byte not latched");
   // codes above 100 leave the channel 0 pin untouched
   chk_ch0_idle: assert property (q.cctl[0][`TCCP_CCTL_CMPM] // R18
      && q.cctl[0][5:3] > `TCCP_CMP_UPCLR |=> $stable(q.pin[0]))
      else $error("channel 0 acted in an unused mode");
   chk_irq_gate: assert property (!q.cfg[`TCCP_CFG_IEN] |-> !irq_req) // R3
      else $error("request without timer enable");
   chk_dma_quiet: assert property (!cmpev[0] |=> !dma_trig[0]) // R21
      else $error("dma trigger without compare");
   // one stall cycle per access, then ready
   chk_bus_stall: assert property (ahb_req.hsel && ahb_req.htrans[1] && ahb_req.hready
      |=> !ahb_rsp.hreadyout ##1 ahb_rsp.hreadyout)
      else $error("bus stall not one cycle");

   // ************************************************
   // main scenarios
   // ************************************************
   cov_free_ovf: cover property (act && q.ctl[1:0] == `TCCP_MODE_FREE && q.cnt == `TCCP_CNT_TOP);
   cov_mod_wrap: cover property (act && q.ctl[1:0] == `TCCP_MODE_MOD && q.cnt == q.cv[0]);
   cov_ud_zero:  cover property (ovf && q.ctl[1:0] == `TCCP_MODE_UPDN);
   cov_capture:  cover property (|capev);
   cov_compare:  cover property (|cmpev);
endmodule : tccp_timer

// ==== tccp_regs.svh ====
`ifndef TCCP_REGS_SVH
`define TCCP_REGS_SVH
// register indices, byte address is four times the index
`define TCCP_IDX_CNTL   8'hE2
`define TCCP_IDX_CNTH   8'hE3
`define TCCP_IDX_CTL    8'hE4
`define TCCP_IDX_CCTL0  8'hE5
`define TCCP_IDX_CVL0   8'hE8
`define TCCP_IDX_CFG    8'hEE
`define TCCP_CNT_ZERO   16'h0000
`define TCCP_CNT_ONE    16'h0001
`define TCCP_CNT_TOP    16'hFFFF
`define TCCP_MODE_STOP  2'h0
`define TCCP_MODE_FREE  2'h1
`define TCCP_MODE_MOD   2'h2
`define TCCP_MODE_UPDN  2'h3
`define TCCP_CMP_SET    3'h0
`define TCCP_CMP_CLR    3'h1
`define TCCP_CMP_TOG    3'h2
`define TCCP_CMP_UPSET  3'h3
`define TCCP_CMP_UPCLR  3'h4
`define TCCP_CAP_RISE   2'h1
`define TCCP_CAP_FALL   2'h2
`define TCCP_CAP_ANY    2'h3
`define TCCP_PSC_DIV1   7'h00
`define TCCP_PSC_DIV8   7'h07
`define TCCP_PSC_DIV32  7'h1F
`define TCCP_PSC_DIV128 7'h7F
`define TCCP_CTL_RST    8'h00
`define TCCP_CCTL_RST   8'h40
`define TCCP_CFG_RST    3'h2
`define TCCP_CTL_OVF    4
`define TCCP_CCTL_IM    6
`define TCCP_CCTL_CMPM  2
`define TCCP_CFG_SHF    0
`define TCCP_CFG_OVFM   1
`define TCCP_CFG_IEN    2
`endif

// ==== tccp_pkg.sv ====
package tccp_pkg;
   typedef struct packed {
      logic        hsel;
      logic [31:0] haddr;
      logic [1:0]  htrans;
      logic        hwrite;
      logic [2:0]  hsize;
      logic        hready;
   } tccp_ahb_req_t;
   typedef struct packed {
      logic        hreadyout;
      logic        hresp;
      logic [31:0] hrdata;
   } tccp_ahb_rsp_t;
   typedef struct packed {
      logic [15:0]      cnt;
      logic             down;
      logic [6:0]       psc;
      logic [7:0]       ctl;
      logic [2:0][7:0]  cctl;
      logic [2:0][15:0] cv;
      logic [2:0][15:0] cvw;
      logic [2:0][7:0]  lob;
      logic [2:0]       pend;
      logic [7:0]       cnth;
      logic [2:0]       s1;
      logic [2:0]       s2;
      logic [2:0]       s3;
      logic [2:0]       pin;
      logic [2:0]       dma;
      logic [2:0]       cfg;
      logic             dph;
      logic             dwr;
      logic [7:0]       didx;
      logic [31:0]      rdata;
   } tccp_state_t;
endpackage : tccp_pkg

// ==== tccp_pin_model.sv ====
// ***************
// far side: event sources and loads
// ***************
module tccp_pin_model (
   // clock
   input  wire logic       hclk,
   // design pins
   input  wire logic [2:0] pin_out,
   input  wire logic [2:0] pin_oe,
   output logic [2:0]      pin_in
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] lvl_q = 3'h0;
   // design wins the wire wherever it drives
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & lvl_q);
   // level held four clocks, well past the one-clock minimum
   task automatic drive(input int ch, input logic v);
      lvl_q[ch] <= v;
      repeat (4) @(posedge hclk);
   endtask : drive
endmodule : tccp_pin_model

// ==== tccp_timer_tb_top.sv ====
`include "tccp_regs.svh"
module tccp_timer_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import tccp_pkg::*;
   logic          hclk    = 1'b0;
   logic          hresetn = 1'b0;
   logic          hsel    = 1'b0;
   logic [31:0]   haddr   = 32'h0;
   logic [1:0]    htrans  = 2'h0;
   logic          hwrite  = 1'b0;
   logic [31:0]   hwdata  = 32'h0;
   logic          tick_en = 1'b0;
   logic [2:0]    pin_in;
   logic [2:0]    pin_out;
   logic [2:0]    pin_oe;
   logic [2:0]    dma_trig;
   logic          irq_req;
   logic          ep;
   int            errors = 0;
   int            checks_done = 0;
   int            dma1 = 0;
   int            n;
   tccp_ahb_req_t ahb_req;
   tccp_ahb_rsp_t ahb_rsp;
   assign ahb_req = '{hsel, haddr, htrans, hwrite, 3'h2, ahb_rsp.hreadyout};
   tccp_timer i_tccp_timer (.hclk(hclk), .hresetn(hresetn), .ahb_req(ahb_req),
      .hwdata(hwdata), .ahb_rsp(ahb_rsp), .tick_en(tick_en), .pin_in(pin_in),
      .pin_out(pin_out), .pin_oe(pin_oe), .irq_req(irq_req), .dma_trig(dma_trig));
   tccp_pin_model i_tccp_pin_model (.hclk(hclk), .pin_out(pin_out), .pin_oe(pin_oe),
      .pin_in(pin_in));
   initial begin
      forever #4 hclk = ~hclk;
   end
   always @(posedge hclk) begin
      if (dma_trig[1] === 1'b1)
         dma1 <= dma1 + 1;
   end
   // ***************
   // bus and checks
   // ***************
   task automatic chk_val(input logic [15:0] g, input logic [15:0] e);
      checks_done++;
      if (g !== e) begin
         errors++;
         $display("Error at %0t: value %h expected %h", $time, g, e);
      end
   endtask : chk_val
   task automatic chk_bit(input logic g, input logic e);
      checks_done++;
      if (g !== e) begin
         errors++;
         $display("Error at %0t: signal %b expected %b", $time, g, e);
      end
   endtask : chk_bit
   // sample on the falling edge: the value the next rising edge sees
   task automatic wait_rdy(output logic [7:0] rd);
      logic rdy;
      int   k;
      k = 0;
      do begin
         @(negedge hclk);
         rdy = ahb_rsp.hreadyout;
         rd  = ahb_rsp.hrdata[7:0];
         @(posedge hclk);
         k++;
      end while (rdy !== 1'b1 && k < 50);
      if (rdy !== 1'b1) begin
         errors++;
         $display("Error at %0t: bus ready timeout", $time);
      end
   endtask : wait_rdy
   task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] wd,
                      output logic [7:0] rd);
      hsel   <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr  <= {22'h0, idx, 2'h0};
      wait_rdy(rd);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= {24'h0, wd};
      wait_rdy(rd);
   endtask : bus
   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      logic [7:0] r;
      bus(1'b1, idx, d, r);
   endtask : wr
   task automatic rd_chk(input logic [7:0] idx, input logic [7:0] e);
      logic [7:0] r;
      bus(1'b0, idx, 8'h00, r);
      chk_val({8'h00, r}, {8'h00, e});
      chk_bit(ahb_rsp.hresp, 1'b0);
   endtask : rd_chk
   task automatic rd_cnt(input logic [15:0] e);
      logic [7:0] lo;
      logic [7:0] hi;
      bus(1'b0, `TCCP_IDX_CNTL, 8'h00, lo);
      bus(1'b0, `TCCP_IDX_CNTH, 8'h00, hi);
      chk_val({hi, lo}, e);
   endtask : rd_cnt
   // tick enables with random idle gaps between them
   task automatic ticks(input int cnt, input int gap);
      int g;
      repeat (cnt) begin
         tick_en <= 1'b1;
         @(posedge hclk);
         g = $urandom_range(gap, 0);
         if (g > 0) begin
            tick_en <= 1'b0;
            repeat (g) @(posedge hclk);
         end
      end
      tick_en <= 1'b0;
   endtask : ticks
   function automatic int div_exp(input int d, input int t);
      return t >> (d == 0 ? 0 : 2 * d + 1);
   endfunction : div_exp
   function automatic logic pin_exp(input int m, input logic p);
      case (m)
         0, 3: return 1'b1;
         2: return ~p;
         default: return 1'b0;
      endcase
   endfunction : pin_exp
   task automatic end_of_test();
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : end_of_test
   initial begin
      // tests take about 70000 clocks; a hang ends at 90000 clocks
      #(90000 * 8);
      errors++;
      end_of_test();
   end
   // ***************
   // scenarios
   // ***************
   initial begin
      void'($urandom(32'hCF2EAC64));
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      rd_chk(`TCCP_IDX_CTL, 8'h00);
      for (int i = 0; i < 3; i++)
         rd_chk(`TCCP_IDX_CCTL0 + 8'(i), 8'h40);
      rd_chk(`TCCP_IDX_CFG, 8'h02);
      wr(8'h10, 8'hFF);
      rd_chk(8'h10, 8'h00);
      $display("test reset done");
      // whole multiples of 128 ticks keep the prescaler phase at zero
      for (int d = 0; d < 4; d++) begin
         wr(`TCCP_IDX_CNTL, 8'h5A);
         wr(`TCCP_IDX_CTL, {4'h0, 2'(d), 2'h1});
         ticks(256, 2);
         wr(`TCCP_IDX_CTL, {4'h0, 2'(d), 2'h0});
         ticks(128, 0);
         rd_cnt(16'(div_exp(d, 256)));
      end
      wr(`TCCP_IDX_CTL, 8'h01);
      ticks(254, 1);
      rd_chk(`TCCP_IDX_CNTL, 8'h00);
      ticks(256, 1);
      rd_chk(`TCCP_IDX_CNTH, 8'h01);
      rd_cnt(16'h0200);
      $display("test count done");
      wr(`TCCP_IDX_CNTL, 8'h00);
      wr(`TCCP_IDX_CFG, 8'h06);
      ticks(65535, 0);
      @(negedge hclk);
      chk_bit(irq_req, 1'b0);
      @(posedge hclk);
      ticks(1, 0);
      @(negedge hclk);
      chk_bit(irq_req, 1'b1);
      @(posedge hclk);
      rd_chk(`TCCP_IDX_CTL, 8'h11);
      rd_chk(`TCCP_IDX_CFG, 8'h07);
      rd_cnt(16'h0000);
      wr(`TCCP_IDX_CFG, 8'h03);
      @(negedge hclk);
      chk_bit(irq_req, 1'b0);
      @(posedge hclk);
      wr(`TCCP_IDX_CFG, 8'h07);
      @(negedge hclk);
      chk_bit(irq_req, 1'b1);
      @(posedge hclk);
      wr(`TCCP_IDX_CTL, 8'hF1);
      rd_chk(`TCCP_IDX_CTL, 8'h11);
      wr(`TCCP_IDX_CTL, 8'h01);
      rd_chk(`TCCP_IDX_CTL, 8'h01);
      $display("test overflow done");
      wr(`TCCP_IDX_CCTL0, 8'h4C);
      wr(`TCCP_IDX_CVL0, 8'h05);
      wr(`TCCP_IDX_CVL0 + 8'h01, 8'h00);
      wr(`TCCP_IDX_CVL0, 8'h09);
      wr(`TCCP_IDX_CTL, 8'h02);
      wr(`TCCP_IDX_CNTL, 8'h00);
      ticks(8, 2);
      rd_cnt(16'h0002);
      rd_chk(`TCCP_IDX_CTL, 8'h32);
      wr(`TCCP_IDX_CVL0, 8'h05);
      wr(`TCCP_IDX_CVL0 + 8'h01, 8'h00);
      wr(`TCCP_IDX_CTL, 8'h03);
      wr(`TCCP_IDX_CNTL, 8'h00);
      ticks(7, 2);
      rd_cnt(16'h0003);
      rd_chk(`TCCP_IDX_CTL, 8'h03);
      ticks(3, 2);
      rd_chk(`TCCP_IDX_CTL, 8'h33);
      rd_cnt(16'h0000);
      $display("test modulo updown done");
      wr(`TCCP_IDX_CCTL0, 8'h40);
      wr(`TCCP_IDX_CTL, 8'h01);
      wr(`TCCP_IDX_CCTL0 + 8'h01, 8'h4C);
      wr(`TCCP_IDX_CVL0 + 8'h02, 8'h03);
      wr(`TCCP_IDX_CVL0 + 8'h03, 8'h00);
      ep = 1'b0;
      for (int m = 0; m < 5; m++) begin
         wr(`TCCP_IDX_CCTL0 + 8'h01, 8'h44 | 8'(m << 3));
         wr(`TCCP_IDX_CNTL, 8'h00);
         n = dma1;
         ticks(5, 2);
         ep = pin_exp(m, ep);
         @(negedge hclk);
         chk_bit(pin_oe[1], 1'b1);
         chk_bit(pin_out[1], ep);
         chk_val(16'(dma1 - n), 16'h0001);
         @(posedge hclk);
      end
      rd_chk(`TCCP_IDX_CTL, 8'h41);
      wr(`TCCP_IDX_CCTL0, 8'h7C);
      wr(`TCCP_IDX_CNTL, 8'h00);
      ticks(8, 2);
      @(negedge hclk);
      chk_bit(pin_oe[0], 1'b1);
      chk_bit(pin_out[0], 1'b0);
      @(posedge hclk);
      wr(`TCCP_IDX_CCTL0, 8'h40);
      $display("test compare done");
      wr(`TCCP_IDX_CCTL0 + 8'h01, 8'h40);
      for (int c = 1; c < 4; c++) begin
         wr(`TCCP_IDX_CCTL0 + 8'h02, 8'h40 | 8'(c));
         wr(`TCCP_IDX_CNTL, 8'h00);
         wr(`TCCP_IDX_CTL, 8'h01);
         ticks(8, 2);
         i_tccp_pin_model.drive(2, 1'b1);
         ticks(4, 2);
         i_tccp_pin_model.drive(2, 1'b0);
         rd_chk(`TCCP_IDX_CVL0 + 8'h04, c == 1 ? 8'h08 : 8'h0C);
         rd_chk(`TCCP_IDX_CVL0 + 8'h05, 8'h00);
         rd_chk(`TCCP_IDX_CTL, 8'h81);
         @(negedge hclk);
         chk_bit(pin_oe[2], 1'b0);
         chk_bit(irq_req, 1'b1);
         @(posedge hclk);
      end
      $display("test capture done");
      end_of_test();
   end
endmodule : tccp_timer_tb_top
